// *** dv/dtc_cpu_model.sv ***
`timescale 1ns/10ps
module dtc_cpu_model
	import dtc_pkg::*;
#(
	parameter int LATENCY = 3
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [3:0] mask,
	input wire dtc_pkg::dtc_irq_t irqReq,
	output dtc_pkg::dtc_irq_t vectorAck
);
	import dtc_pkg::*;
	int waitCnt;
	// Vectors into a routine a few cycles after an enabled request
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			waitCnt <= 0;
			vectorAck <= '0;
		end else begin
			vectorAck <= '0;
			if (waitCnt != 0) begin
				waitCnt <= waitCnt - 1;
				if (waitCnt == 1) begin
					vectorAck <= dtc_irq_t'(irqReq & mask);
				end
			end else if ((irqReq & mask) != 4'h0) begin
				waitCnt <= LATENCY;
			end
		end
	end
endmodule

// *** dv/dtc_timer_bench.sv ***
`timescale 1ns/10ps
`include "dtc_cfg.svh"
module dtc_timer_bench;
	import dtc_pkg::*;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	dtc_bus_t busReq = '0;
	logic [7:0] rdData;
	dtc_irq_t vectorAck;
	dtc_irq_t irqReq;
	logic [3:0] pins = 4'hF;
	logic [3:0] mask = 4'h0;
	int nErrors = 0;
	int checksDone = 0;
	always #5 clk = ~clk;
	dtc_timer i_dtc_timer (.clk(clk), .rst_n(rst_n), .busReq(busReq),
		.rdData(rdData), .vectorAck(vectorAck), .irqReq(irqReq),
		.extIrq0Pin(pins[0]), .extIrq1Pin(pins[1]),
		.counter0Pin(pins[2]), .counter1Pin(pins[3]));
	dtc_cpu_model i_dtc_cpu_model (.clk(clk), .rst_n(rst_n), .mask(mask),
		.irqReq(irqReq), .vectorAck(vectorAck));
	task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
		checksDone++;
		if (g !== e) begin
			$display("MISMATCH %s expected %h seen %h", nm, e, g);
			nErrors++;
		end
	endtask
	task automatic wrReg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		busReq <= '{1'b0, 1'b1, a, d};
		@(posedge clk);
		busReq <= '0;
	endtask
	task automatic rdChk(input logic [7:0] a, input logic [7:0] e);
		@(posedge clk);
		busReq <= '{1'b1, 1'b0, a, 8'h00};
		@(posedge clk);
		busReq <= '0;
		#1;
		chk($sformatf("reg %h", a), e, rdData);
	endtask
	task automatic irqChk(input logic [3:0] e);
		#1;
		chk("irqReq", {4'h0, e}, {4'h0, irqReq});
	endtask
	// Run window of exactly 20 edges, so 10 divider ticks
	task automatic runFor(input logic [7:0] on);
		wrReg(`DTC_ADDR_CTRL, on);
		repeat (18) @(posedge clk);
		wrReg(`DTC_ADDR_CTRL, 8'h00);
	endtask
	task automatic pulse(input int p);
		@(posedge clk);
		pins[p] <= 1'b0;
		repeat (4) @(posedge clk);
		pins[p] <= 1'b1;
		repeat (4) @(posedge clk);
	endtask
	task automatic setT0(input logic [7:0] m, input logic [7:0] h, input logic [7:0] l);
		wrReg(`DTC_ADDR_MODE, m);
		wrReg(`DTC_ADDR_TH0, h);
		wrReg(`DTC_ADDR_TL0, l);
	endtask
	task automatic completeRun;
		$display("checks %0d errors %0d", checksDone, nErrors);
		if (nErrors == 0 && checksDone > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask
	initial begin
		#200000;
		nErrors++;
		completeRun();
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		repeat (3) @(posedge clk);
		for (int i = 0; i < 6; i++) begin
			rdChk(8'h88 + 8'(i), 8'h00);
		end
		rdChk(8'h8E, 8'h00);
		for (int i = 2; i < 6; i++) begin
			wrReg(8'h88 + 8'(i), 8'h5A + 8'(i));
			rdChk(8'h88 + 8'(i), 8'h5A + 8'(i));
		end
		setT0(8'h01, 8'h00, 8'h00);
		runFor(8'h10);
		rdChk(`DTC_ADDR_TL0, 8'h0A);
		repeat (10) @(posedge clk);
		rdChk(`DTC_ADDR_TL0, 8'h0A);
		setT0(8'h01, 8'hFF, 8'hFE);
		runFor(8'h10);
		rdChk(`DTC_ADDR_TH0, 8'h00);
		rdChk(`DTC_ADDR_TL0, 8'h08);
		setT0(8'h02, 8'hF0, 8'hFE);
		runFor(8'h10);
		rdChk(`DTC_ADDR_TL0, 8'hF8);
		wrReg(`DTC_ADDR_MODE, 8'h00);
		wrReg(`DTC_ADDR_TH1, 8'h00);
		wrReg(`DTC_ADDR_TL1, 8'h1E);
		runFor(8'h40);
		rdChk(`DTC_ADDR_TH1, 8'h01);
		rdChk(`DTC_ADDR_TL1, 8'h08);
		wrReg(`DTC_ADDR_MODE, 8'h30);
		wrReg(`DTC_ADDR_TL1, 8'h05);
		runFor(8'h40);
		rdChk(`DTC_ADDR_TL1, 8'h05);
		setT0(8'h09, 8'h00, 8'h00);
		pins[0] <= 1'b0;
		repeat (4) @(posedge clk);
		runFor(8'h10);
		rdChk(`DTC_ADDR_TL0, 8'h00);
		pins[0] <= 1'b1;
		repeat (4) @(posedge clk);
		runFor(8'h10);
		rdChk(`DTC_ADDR_TL0, 8'h0A);
		setT0(8'h05, 8'h00, 8'h00);
		wrReg(`DTC_ADDR_CTRL, 8'h10);
		repeat (3) pulse(2);
		rdChk(`DTC_ADDR_TL0, 8'h03);
		wrReg(`DTC_ADDR_CTRL, 8'h00);
		setT0(8'h01, 8'hFF, 8'hFF);
		wrReg(`DTC_ADDR_CTRL, 8'h10);
		repeat (6) @(posedge clk);
		irqChk(4'b0100);
		mask <= 4'b0100;
		repeat (8) @(posedge clk);
		irqChk(4'b0000);
		mask <= 4'h0;
		wrReg(`DTC_ADDR_CTRL, 8'h01);
		pulse(0);
		rdChk(`DTC_ADDR_CTRL, 8'h03);
		wrReg(`DTC_ADDR_CTRL, 8'h04);
		pulse(1);
		rdChk(`DTC_ADDR_CTRL, 8'h0C);
		mask <= 4'b0010;
		repeat (8) @(posedge clk);
		irqChk(4'b0000);
		mask <= 4'h0;
		wrReg(`DTC_ADDR_CTRL, 8'h00);
		pins[1] <= 1'b0;
		repeat (5) @(posedge clk);
		wrReg(`DTC_ADDR_CTRL, 8'h00);
		@(posedge clk);
		irqChk(4'b0010);
		pins[1] <= 1'b1;
		repeat (4) @(posedge clk);
		wrReg(`DTC_ADDR_CTRL, 8'h00);
		irqChk(4'b0000);
		wrReg(`DTC_ADDR_CTRL, 8'hA0);
		irqChk(4'b1100);
		wrReg(`DTC_ADDR_CTRL, 8'h00);
		wrReg(`DTC_ADDR_MODE, 8'h10);
		wrReg(`DTC_ADDR_TH1, 8'hFF);
		wrReg(`DTC_ADDR_TL1, 8'hFF);
		wrReg(`DTC_ADDR_CTRL, 8'h40);
		repeat (6) @(posedge clk);
		irqChk(4'b1000);
		mask <= 4'b1000;
		repeat (8) @(posedge clk);
		irqChk(4'b0000);
		mask <= 4'h0;
		wrReg(`DTC_ADDR_CTRL, 8'h00);
		setT0(8'h03, 8'hFF, 8'h00);
		wrReg(`DTC_ADDR_CTRL, 8'h40);
		repeat (6) @(posedge clk);
		irqChk(4'b1000);
		rdChk(`DTC_ADDR_TL0, 8'h00);
		completeRun();
	end
endmodule

// *** hdl/dtc_timer.sv ***
`timescale 1ns/10ps
`include "dtc_cfg.svh"
module dtc_timer (
	input wire logic clk,
	input wire logic rst_n,
	input wire dtc_pkg::dtc_bus_t busReq,
	output logic [7:0] rdData,
	input wire dtc_pkg::dtc_irq_t vectorAck,
	output dtc_pkg::dtc_irq_t irqReq,
	input wire logic extIrq0Pin,
	input wire logic extIrq1Pin,
	input wire logic counter0Pin,
	input wire logic counter1Pin
);
	import dtc_pkg::*;

	logic rstMeta;
	logic rst;
	logic [3:0] pinMeta;
	logic [3:0] pinSync;
	logic [3:0] pinLast;
	logic divPhase;
	logic [7:0] ctrl;
	logic [7:0] mode;
	logic [7:0] tl0;
	logic [7:0] th0;
	logic [7:0] tl1;
	logic [7:0] th1;
	logic [7:0] next_ctrl;
	logic [7:0] next_tl0;
	logic [7:0] next_th0;
	logic [7:0] next_tl1;
	logic [7:0] next_th1;

	default clocking dtcClk @(posedge clk);
	endclocking
	default disable iff (!rst);

	// Next {overflow, high, low} for modes 00, 01 and 10
	function automatic logic [16:0] stepTimer(input logic [7:0] hi,
			input logic [7:0] lo, input logic [1:0] m);
		logic [16:0] res;
		res = {1'b0, hi, lo};
		case (m)
			DTC_MODE_PRESC: begin
				if (lo[4:0] == `DTC_PRESC_MAX) begin
					res[4:0] = `DTC_PRESC_ZERO;
					res[15:8] = hi + `DTC_ONE8;
					res[16] = (hi == `DTC_BYTE_MAX);
				end else begin
					res[4:0] = lo[4:0] + 5'h01;
				end
			end
			DTC_MODE_WORD: begin
				res[15:0] = {hi, lo} + `DTC_ONE16;
				res[16] = ({hi, lo} == `DTC_WORD_MAX);
			end
			DTC_MODE_RELOAD: begin
				res[7:0] = (lo == `DTC_BYTE_MAX) ? hi : lo + `DTC_ONE8;
				res[16] = (lo == `DTC_BYTE_MAX);
			end
			default: begin
				res = {1'b0, hi, lo};
			end
		endcase
		return res;
	endfunction

	// Reset release through two flops
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			rstMeta <= 1'b0;
			rst <= 1'b0;
		end else begin
			rstMeta <= 1'b1;
			rst <= rstMeta;
		end
	end

	// Pins idle high so the reset value cannot fake a falling edge
	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			pinMeta <= `DTC_PIN_RST;
			pinSync <= `DTC_PIN_RST;
			pinLast <= `DTC_PIN_RST;
			divPhase <= 1'b0;
		end else begin
			pinMeta <= {counter1Pin, counter0Pin, extIrq1Pin, extIrq0Pin};
			pinSync <= pinMeta;
			pinLast <= pinSync;
			divPhase <= ~divPhase;
		end
	end

	wire [3:0] pinFall = pinLast & ~pinSync;
	wire sysTick = divPhase;
	wire wrCtrl = busReq.wr && busReq.addr == `DTC_ADDR_CTRL;
	wire wrMode = busReq.wr && busReq.addr == `DTC_ADDR_MODE;
	wire wrTl0 = busReq.wr && busReq.addr == `DTC_ADDR_TL0;
	wire wrTl1 = busReq.wr && busReq.addr == `DTC_ADDR_TL1;
	wire wrTh0 = busReq.wr && busReq.addr == `DTC_ADDR_TH0;
	wire wrTh1 = busReq.wr && busReq.addr == `DTC_ADDR_TH1;
	wire [1:0] mode0 = mode[`DTC_M0];
	wire [1:0] mode1 = mode[`DTC_M1];
	wire split0 = mode0 == DTC_MODE_SPLIT;

	wire gate0Ok = !mode[`DTC_PIN_GATING0_SEL] || pinSync[`DTC_PIN_EXT0];
	wire gate1Ok = !mode[`DTC_PIN_GATING1_SEL] || pinSync[`DTC_PIN_EXT1];
	wire run0 = ctrl[`DTC_TR0] && gate0Ok;
	wire run1 = ctrl[`DTC_TR1] && gate1Ok && mode1 != DTC_MODE_SPLIT;
	wire src0 = mode[`DTC_CT0] ? pinFall[`DTC_PIN_CNT0] : sysTick;
	wire src1 = mode[`DTC_CT1] ? pinFall[`DTC_PIN_CNT1] : sysTick;
	wire inc0 = run0 && src0;
	wire inc1 = run1 && src1;
	// Split high byte is a plain timer on Timer1's run bit
	wire incTh0 = split0 && ctrl[`DTC_TR1] && sysTick;

	wire [16:0] step0 = stepTimer(th0, tl0, mode0);
	wire [16:0] step1 = stepTimer(th1, tl1, mode1);
	wire tl0Wrap = tl0 == `DTC_BYTE_MAX;
	wire th0Wrap = th0 == `DTC_BYTE_MAX;
	wire ovf0Evt = inc0 && (split0 ? tl0Wrap : step0[16]);
	// Timer1 loses its flag to the split high byte
	wire ovf1Evt = split0 ? (incTh0 && th0Wrap) : (inc1 && step1[16]);
	wire ext0Evt = ctrl[`DTC_IT0] ? pinFall[`DTC_PIN_EXT0]
		: !pinSync[`DTC_PIN_EXT0];
	wire ext1Evt = ctrl[`DTC_IT1] ? pinFall[`DTC_PIN_EXT1]
		: !pinSync[`DTC_PIN_EXT1];

	// Hardware set wins over software clear and vector acknowledge
	always_comb begin
		next_ctrl = wrCtrl ? busReq.wdata : ctrl;
		if (!wrCtrl) begin
			next_ctrl[`DTC_TF1] = ctrl[`DTC_TF1] && !vectorAck.ovf1;
			next_ctrl[`DTC_TF0] = ctrl[`DTC_TF0] && !vectorAck.ovf0;
			next_ctrl[`DTC_IE1] = ctrl[`DTC_IE1] && !vectorAck.ext1;
			next_ctrl[`DTC_IE0] = ctrl[`DTC_IE0] && !vectorAck.ext0;
		end
		next_ctrl[`DTC_TF1] = next_ctrl[`DTC_TF1] || ovf1Evt;
		next_ctrl[`DTC_TF0] = next_ctrl[`DTC_TF0] || ovf0Evt;
		next_ctrl[`DTC_IE1] = next_ctrl[`DTC_IE1] || ext1Evt;
		next_ctrl[`DTC_IE0] = next_ctrl[`DTC_IE0] || ext0Evt;
	end

	// Software writes to a count byte win over counting
	always_comb begin
		next_tl0 = tl0;
		next_th0 = th0;
		if (split0) begin
			if (inc0) begin
				next_tl0 = tl0 + `DTC_ONE8;
			end
			if (incTh0) begin
				next_th0 = th0 + `DTC_ONE8;
			end
		end else if (inc0) begin
			next_tl0 = step0[7:0];
			next_th0 = step0[15:8];
		end
		if (wrTl0) begin
			next_tl0 = busReq.wdata;
		end
		if (wrTh0) begin
			next_th0 = busReq.wdata;
		end
	end

	always_comb begin
		next_tl1 = inc1 ? step1[7:0] : tl1;
		next_th1 = inc1 ? step1[15:8] : th1;
		if (wrTl1) begin
			next_tl1 = busReq.wdata;
		end
		if (wrTh1) begin
			next_th1 = busReq.wdata;
		end
	end

	wire [7:0] rdMux =
		(busReq.addr == `DTC_ADDR_CTRL) ? ctrl :
		(busReq.addr == `DTC_ADDR_MODE) ? mode :
		(busReq.addr == `DTC_ADDR_TL0) ? tl0 :
		(busReq.addr == `DTC_ADDR_TL1) ? tl1 :
		(busReq.addr == `DTC_ADDR_TH0) ? th0 :
		(busReq.addr == `DTC_ADDR_TH1) ? th1 : `DTC_RST_BYTE;

	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			ctrl <= `DTC_RST_BYTE;
			mode <= `DTC_RST_BYTE;
			tl0 <= `DTC_RST_BYTE;
			th0 <= `DTC_RST_BYTE;
			tl1 <= `DTC_RST_BYTE;
			th1 <= `DTC_RST_BYTE;
		end else begin
			ctrl <= next_ctrl;
			mode <= wrMode ? busReq.wdata : mode;
			tl0 <= next_tl0;
			th0 <= next_th0;
			tl1 <= next_tl1;
			th1 <= next_th1;
		end
	end

	// Read data stand only in the cycle after the strobe
	always_ff @(posedge clk or negedge rst) begin
		if (!rst) begin
			rdData <= `DTC_RST_BYTE;
			irqReq <= '0;
		end else begin
			rdData <= busReq.rd ? rdMux : `DTC_RST_BYTE;
			irqReq <= '{ovf1: next_ctrl[`DTC_TF1], ovf0: next_ctrl[`DTC_TF0],
				ext1: next_ctrl[`DTC_IE1], ext0: next_ctrl[`DTC_IE0]};
		end
	end

	// Flags: hardware set, vector clear
	AST_TF1_SET: assert property (ovf1Evt
		|=> ctrl[`DTC_TF1] && irqReq.ovf1)
		else $error("Timer1 overflow did not set its flag");
	AST_TF1_ACK: assert property (ctrl[`DTC_TF1] && vectorAck.ovf1
		&& !wrCtrl && !ovf1Evt |=> !ctrl[`DTC_TF1])
		else $error("Timer1 flag not cleared on vector entry");
	AST_TF0_SET: assert property (ovf0Evt
		|=> ctrl[`DTC_TF0] && irqReq.ovf0)
		else $error("Timer0 overflow did not set its flag");
	AST_TF0_ACK: assert property (ctrl[`DTC_TF0] && vectorAck.ovf0
		&& !wrCtrl && !ovf0Evt |=> !ctrl[`DTC_TF0])
		else $error("Timer0 flag not cleared on vector entry");
	AST_IRQ_MIRROR: assert property (irqReq.ovf1 == ctrl[`DTC_TF1]
		&& irqReq.ovf0 == ctrl[`DTC_TF0] && irqReq.ext1 == ctrl[`DTC_IE1]
		&& irqReq.ext0 == ctrl[`DTC_IE0])
		else $error("Request lines differ from the flag bits");

	// Run control
	AST_RUN_HOLD: assert property (!ctrl[`DTC_TR0] && !wrTl0
		|=> tl0 == $past(tl0))
		else $error("Timer0 low byte moved while stopped");
	AST_RUN1_HOLD: assert property (!ctrl[`DTC_TR1] && !wrTl1
		&& !wrTh1 |=> $stable(tl1) && $stable(th1))
		else $error("Timer1 moved while stopped");
	AST_T0_RUNS: assert property (ctrl[`DTC_TR0] && !mode[`DTC_PIN_GATING0_SEL]
		&& !mode[`DTC_CT0] && sysTick |-> inc0)
		else $error("Timer0 did not step while running");
	AST_T1_RUNS: assert property (ctrl[`DTC_TR1] && !mode[`DTC_PIN_GATING1_SEL]
		&& !mode[`DTC_CT1] && mode1 != DTC_MODE_SPLIT && sysTick |-> inc1)
		else $error("Timer1 did not step while running");

	// External interrupt flags
	AST_EXT1_EDGE: assert property (ctrl[`DTC_IT1]
		&& $fell(pinSync[`DTC_PIN_EXT1]) |=> ctrl[`DTC_IE1])
		else $error("External 1 falling edge not flagged");
	AST_EXT1_ACK: assert property (ctrl[`DTC_IE1] && vectorAck.ext1
		&& !wrCtrl && !ext1Evt |=> !ctrl[`DTC_IE1])
		else $error("External 1 flag not cleared on vector entry");
	AST_EXT0_EDGE: assert property (ctrl[`DTC_IT0]
		&& $fell(pinSync[`DTC_PIN_EXT0]) |=> ctrl[`DTC_IE0])
		else $error("External 0 falling edge not flagged");
	AST_EXT0_ACK: assert property (ctrl[`DTC_IE0] && vectorAck.ext0
		&& !wrCtrl && !ext0Evt |=> !ctrl[`DTC_IE0])
		else $error("External 0 flag not cleared on vector entry");
	AST_EXT0_LEVEL: assert property (!ctrl[`DTC_IT0]
		&& !pinSync[`DTC_PIN_EXT0] |=> ctrl[`DTC_IE0])
		else $error("External 0 low level not flagged");
	AST_EXT1_LEVEL: assert property (!ctrl[`DTC_IT1]
		&& !pinSync[`DTC_PIN_EXT1] |=> ctrl[`DTC_IE1])
		else $error("External 1 low level not flagged");
	AST_EDGE_ONLY: assert property (ctrl[`DTC_IT1] && !ctrl[`DTC_IE1]
		&& !pinFall[`DTC_PIN_EXT1] && !wrCtrl |=> !ctrl[`DTC_IE1])
		else $error("External 1 flag set with no falling edge");

	// Gating and count source
	AST_GATE_LOW: assert property (mode[`DTC_PIN_GATING0_SEL]
		&& !pinSync[`DTC_PIN_EXT0] |-> !inc0)
		else $error("Gated Timer0 counted with its pin low");
	AST_PIN_GATING1_SEL_LOW: assert property (mode[`DTC_PIN_GATING1_SEL]
		&& !pinSync[`DTC_PIN_EXT1] |-> !inc1)
		else $error("Gated Timer1 counted with its pin low");
	AST_TICK_RATE: assert property (inc1 && !mode[`DTC_CT1] && !wrMode
		|=> !inc1 ##1 (!ctrl[`DTC_TR1] || !gate1Ok || mode[`DTC_CT1]
		|| mode1 == DTC_MODE_SPLIT || inc1))
		else $error("Timer1 timer mode not one step per two cycles");
	AST_TICK0_RATE: assert property (inc0 && !mode[`DTC_CT0] && !wrMode
		|=> !inc0)
		else $error("Timer0 timer mode stepped on two cycles in a row");
	AST_PIN_COUNT: assert property (mode[`DTC_CT0] && inc0
		|-> $past(pinSync[`DTC_PIN_CNT0]) && !pinSync[`DTC_PIN_CNT0])
		else $error("Counter mode stepped without a pin falling edge");
	AST_PIN1_COUNT: assert property (mode[`DTC_CT1] && inc1
		|-> $past(pinSync[`DTC_PIN_CNT1]) && !pinSync[`DTC_PIN_CNT1])
		else $error("Timer1 counter mode stepped without a falling edge");

	// Count modes
	AST_PRESC_CARRY: assert property (mode0 == DTC_MODE_PRESC && inc0
		&& tl0[4:0] == `DTC_PRESC_MAX && !wrTl0 && !wrTh0
		|=> tl0[4:0] == `DTC_PRESC_ZERO && th0 == $past(th0) + `DTC_ONE8)
		else $error("Prescaler wrap did not step the high byte");
	AST_PRESC_HOLD: assert property (mode0 == DTC_MODE_PRESC && inc0
		&& tl0[4:0] != `DTC_PRESC_MAX && !wrTh0 |=> $stable(th0))
		else $error("High byte stepped before the prescaler wrapped");
	AST_WORD_STEP: assert property (mode0 == DTC_MODE_WORD && inc0
		&& !wrTl0 && !wrTh0
		|=> {th0, tl0} == $past({th0, tl0}) + `DTC_ONE16)
		else $error("16-bit count did not step by one");
	AST_WORD_WRAP: assert property (mode0 == DTC_MODE_WORD && inc0
		&& tl0 == `DTC_BYTE_MAX && th0 == `DTC_BYTE_MAX && !wrTl0 && !wrTh0
		|=> tl0 == `DTC_RST_BYTE && th0 == `DTC_RST_BYTE
		&& ctrl[`DTC_TF0])
		else $error("16-bit wrap wrong");
	AST_T1_WORD_WRAP: assert property (mode1 == DTC_MODE_WORD && inc1
		&& !split0 && tl1 == `DTC_BYTE_MAX && th1 == `DTC_BYTE_MAX
		|=> ctrl[`DTC_TF1])
		else $error("Timer1 16-bit wrap did not set its flag");
	AST_RELOAD: assert property (mode0 == DTC_MODE_RELOAD && inc0
		&& tl0Wrap && !wrTl0 && !wrTh0 |=> tl0 == $past(th0))
		else $error("Auto-reload did not load the high byte");
	AST_RELOAD_FLAG: assert property (mode0 == DTC_MODE_RELOAD && inc0
		&& tl0Wrap |=> ctrl[`DTC_TF0])
		else $error("Auto-reload overflow did not set the flag");
	AST_T1_STOP: assert property (mode1 == DTC_MODE_SPLIT
		&& !wrTl1 && !wrTh1 |=> $stable(tl1) && $stable(th1))
		else $error("Timer1 moved in mode 11");
	AST_SPLIT_LOW: assert property (split0 && inc0 && !wrTl0
		|=> tl0 == $past(tl0) + `DTC_ONE8)
		else $error("Split low byte did not step by one");
	AST_SPLIT_HIGH: assert property (split0 && incTh0 && !wrTh0
		|=> th0 == $past(th0) + `DTC_ONE8)
		else $error("Split high byte did not step by one");
	AST_SPLIT_FLAG: assert property (split0 && incTh0 && th0Wrap
		|=> ctrl[`DTC_TF1])
		else $error("Split high byte wrap did not set the Timer1 flag");

	// Software access and pin edge detection
	AST_WR_TL0: assert property (wrTl0
		|=> tl0 == $past(busReq.wdata))
		else $error("Low byte write did not land");
	AST_WR_TH1: assert property (wrTh1
		|=> th1 == $past(busReq.wdata))
		else $error("Timer1 high byte write did not land");
	AST_RD_TL0: assert property (busReq.rd
		&& busReq.addr == `DTC_ADDR_TL0 |=> rdData == $past(tl0))
		else $error("Low byte read returned the wrong value");
	AST_RD_ZERO: assert property (!busReq.rd
		|=> rdData == `DTC_RST_BYTE)
		else $error("Read data outside the answer cycle");
	AST_SW_FLAG: assert property (wrCtrl && !ovf0Evt
		|=> ctrl[`DTC_TF0] == $past(busReq.wdata[`DTC_TF0]))
		else $error("Software write to the Timer0 flag did not land");
	AST_FALL_ONCE: assert property (pinFall[`DTC_PIN_CNT0]
		|=> !pinFall[`DTC_PIN_CNT0])
		else $error("One pin fall seen on two cycles");
endmodule

// *** inc/dtc_cfg.svh ***
`ifndef DTC_CFG_SVH
`define DTC_CFG_SVH
// Function
// - A Timer1 overflow sets overflow1_flag, and entry to its service routine clears it.
// - A Timer0 overflow sets overflow0_flag, and entry to its service routine clears it.
// - A timer counts only while its run bit (Timer1 bit 6, Timer0 bit 4) is 1, else it holds.
// - A falling edge on ext_irq1_pin sets ext_irq1_flag whatever the enable, and entry clears it.
// - A falling edge on ext_irq0_pin sets ext_irq0_flag whatever the enable, and entry clears it.
// - Trigger select (bit 2 for pin 1, bit 0 for pin 0) picks low level at 0 and falling edge at 1.
// - With gating set a timer runs only while its interrupt pin is high and its run bit is set.
// - In timer mode a timer increments once every 2 system clock cycles.
// - In counter mode a timer increments on each falling edge of its count pin.
// - Mode 00 is an 8-bit counter in the high byte behind a 5-bit prescaler in the low byte.
// - Mode 01 is a 16-bit counter that overflows when it wraps past all ones.
// - Mode 10 counts the low byte and reloads it from the high byte on each overflow.
// - Mode 11 stops Timer1 whatever its run bit says.
// - Timer0 mode 11 makes the low byte a timer/counter and the high byte a timer on Timer1's run bit and flag.
// - The four count bytes are read/write and reset to zero.

`define DTC_ADDR_CTRL 8'h88
`define DTC_ADDR_MODE 8'h89
`define DTC_ADDR_TL0 8'h8A
`define DTC_ADDR_TL1 8'h8B
`define DTC_ADDR_TH0 8'h8C
`define DTC_ADDR_TH1 8'h8D
`define DTC_RST_BYTE 8'h00
`define DTC_BYTE_MAX 8'hFF
`define DTC_PRESC_MAX 5'h1F
`define DTC_PRESC_ZERO 5'h00
`define DTC_ONE8 8'h01
`define DTC_ONE16 16'h0001
`define DTC_WORD_MAX 16'hFFFF
`define DTC_PIN_RST 4'hF
// Timer control bits
`define DTC_TF1 7
`define DTC_TR1 6
`define DTC_TF0 5
`define DTC_TR0 4
`define DTC_IE1 3
`define DTC_IT1 2
`define DTC_IE0 1
`define DTC_IT0 0
// Timer mode bits
`define DTC_PIN_GATING1_SEL 7
`define DTC_CT1 6
`define DTC_M1 5:4
`define DTC_PIN_GATING0_SEL 3
`define DTC_CT0 2
`define DTC_M0 1:0
// Synchronised pin indices
`define DTC_PIN_EXT0 0
`define DTC_PIN_EXT1 1
`define DTC_PIN_CNT0 2
`define DTC_PIN_CNT1 3
`endif

// *** inc/dtc_pkg.sv ***
package dtc_pkg;
	typedef enum logic [1:0] {
		DTC_MODE_PRESC = 2'h0,
		DTC_MODE_WORD = 2'h1,
		DTC_MODE_RELOAD = 2'h2,
		DTC_MODE_SPLIT = 2'h3
	} dtc_mode_t;
	typedef struct packed {
		logic rd;
		logic wr;
		logic [7:0] addr;
		logic [7:0] wdata;
	} dtc_bus_t;
	typedef struct packed {
		logic ovf1;
		logic ovf0;
		logic ext1;
		logic ext0;
	} dtc_irq_t;
endpackage
